// *** deq_pkg.sv ***
// Shared constants and types for the endpoint queue head engine
package deq_pkg;
   localparam int          DEQ_FIFO_DEPTH  = 16;
   localparam int          DEQ_FIFO_WIDTH  = 32;
   localparam int          DEQ_MEM_WORDS   = 256;
   localparam logic [31:0] DEQ_QH_REGION   = 32'h0000_0800;
   localparam int          DEQ_QH_SHIFT    = 6;
   localparam logic [31:0] DEQ_QH_BYTES    = 32'h0000_0030;
   localparam logic [31:0] DEQ_QH_CAP      = 32'h0000_0000;
   localparam logic [31:0] DEQ_QH_CUR      = 32'h0000_0004;
   localparam logic [31:0] DEQ_QH_OVL      = 32'h0000_0008;
   localparam logic [31:0] DEQ_QH_TOK      = 32'h0000_000c;
   localparam logic [31:0] DEQ_QH_BUF0     = 32'h0000_0010;
   localparam logic [31:0] DEQ_QH_OVL_END  = 32'h0000_0020;
   localparam logic [31:0] DEQ_QH_SETUP0   = 32'h0000_0028;
   localparam logic [31:0] DEQ_DTD_TOK     = 32'h0000_0004;
   localparam logic [31:0] DEQ_DTD_MASK    = 32'hffff_ffe0;
   localparam logic [2:0]  DEQ_OVL_LAST    = 3'h6;
   localparam logic [10:0] DEQ_MPL_MAX     = 11'h400;
   localparam int          DEQ_CAP_MULT_HI = 31;
   localparam int          DEQ_CAP_MULT_LO = 30;
   localparam int          DEQ_CAP_ZLT     = 29;
   localparam int          DEQ_CAP_MPL_HI  = 26;
   localparam int          DEQ_CAP_MPL_LO  = 16;
   localparam int          DEQ_CAP_IOS     = 15;
   localparam int          DEQ_TOK_BYT_HI  = 30;
   localparam int          DEQ_TOK_BYT_LO  = 16;
   localparam int          DEQ_TOK_IOC     = 15;
   localparam int          DEQ_TOK_ACTIVE  = 7;
   localparam int          DEQ_TOK_HALTED  = 6;
   localparam int          DEQ_NEXT_T      = 0;
   typedef enum logic [1:0] {DEQ_EVT_SETUP, DEQ_EVT_OUT, DEQ_EVT_IN} deq_evt_t;
endpackage

// *** deq_mem_if.sv ***
// Shared memory port between the queue engine and the memory end
`timescale 1ns/1ns
interface deq_mem_if;
   logic        req;
   logic        we;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        ack;
   modport ctrl (output req, we, addr, wdata, input rdata, ack);
   modport mem  (input req, we, addr, wdata, output rdata, ack);
endinterface

// *** deq_controller.sv ***
// Endpoint queue head engine with its receive data FIFO
// Function
// - One IN and one OUT head per endpoint
// - Head array starts at list base address
// - Software keeps structures inside one 4K page
// - Heads are 48 bytes on 64-byte stride
// - Priming copies descriptor into overlay 0x08-0x20
// - Completion writes status back, then advances queue unless halted
// - Fixed head layout: capabilities, current, overlay, setup
// - Mult field selects derived or 1-3 packets
// - Software sets mult zero unless isochronous
// - Transmit appends zero packet when termination enabled
// - Receive waits zero packet after full last packet
// - Termination disabled: no zero packet, retire early
// - Max packet length field, at most 0x400
// - Setup raises transfer flag when INTERRUPT_ON_SETUP_FLAG set
// - Software keeps capabilities fixed while enabled
// - Engine alone loads current pointer, low bits zero
// - Inactive overlay means endpoint not serviced
// - Software leaves overlay and descriptor during transfer
// - Setup bytes stored in two longwords
// - Setup captured only into receive head
// - Active descriptor: software changes next pointer only
// - Token bit 7 marks active descriptor
// - Setting halted also clears active
`timescale 1ns/1ns
module deq_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Fill side
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   // Drain side
   output logic                  o_valid,
   output logic [WIDTH-1:0]      o_data,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push = i_valid && o_ready;
   wire              pop  = o_valid && i_ready;
   wire  [AW:0]      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign o_data = store[rd_ptr];
   always_ff @(posedge i_clk) begin
      if (push) begin
         store[wr_ptr] <= i_data;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count   <= '0;
         o_ready <= 1'b1;
         o_valid <= 1'b0;
      end else begin
         wr_ptr  <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
         rd_ptr  <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
         count   <= next_count;
         o_ready <= next_count != (AW + 1)'(DEPTH);
         o_valid <= next_count != '0;
      end
   end
endmodule

module deq_controller
   import deq_pkg::*;
#(
   parameter int FIFO_DEPTH = DEQ_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Configuration
   input  wire logic [31:0] i_endpoint_list_base,
   // Priming
   input  wire logic        i_prime_valid,
   input  wire logic [3:0]  i_prime_ep,
   input  wire logic        i_prime_dir,
   // Bus events
   input  wire logic        i_evt_valid,
   input  wire deq_evt_t    i_evt_kind,
   input  wire logic [3:0]  i_evt_ep,
   input  wire logic [10:0] i_evt_len,
   input  wire logic        i_evt_err,
   output logic             o_ready,
   // Received data words
   input  wire logic        i_rx_valid,
   input  wire logic [31:0] i_rx_data,
   output logic             o_rx_ready,
   // Transmit and status
   output logic             o_tx_valid,
   output logic [10:0]      o_tx_len,
   output logic             o_transfer_interrupt_flag,
   // Shared memory
   deq_mem_if.ctrl          mem
);
   typedef enum logic [4:0] {
      S_IDLE, S_NEXT_RD, S_COPY_RD, S_COPY_WR, S_CUR_WR, S_CAP_RD, S_TOK_RD, S_BUF_RD,
      S_DISPATCH, S_SETUP_WR, S_RX_WR, S_DRAIN, S_TX, S_TOK_WR, S_BUF_WR, S_CUR_RD, S_WB_WR
   } deq_state_t;

   deq_state_t  state;
   logic [3:0]  ep_q;
   logic        dir_q;
   deq_evt_t    kind_q;
   logic [10:0] len_q;
   logic        err_q;
   logic [31:0] cap;
   logic [31:0] tok;
   logic [31:0] buf0;
   logic [31:0] nptr;
   logic [31:0] copy_q;
   logic [2:0]  k;
   logic [9:0]  wcnt;
   logic [1:0]  pcnt;
   logic        retire_q;
   logic        advance_q;
   logic        mreq;
   logic        mwe;
   logic [31:0] maddr;
   logic [31:0] mwdata;
   logic        f_valid;
   logic [31:0] f_data;
   logic        f_pop;

   deq_fifo #(.WIDTH(DEQ_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_valid (i_rx_valid),
      .i_data  (i_rx_data),
      .o_ready (o_rx_ready),
      .o_valid (f_valid),
      .o_data  (f_data),
      .i_ready (f_pop)
   );

   // Head address from list base and endpoint/direction
   wire [31:0] qh       = i_endpoint_list_base + {21'h0, ep_q, dir_q, 6'h0};
   wire [1:0]  mult     = cap[DEQ_CAP_MULT_HI:DEQ_CAP_MULT_LO];
   wire        zlt_dis  = cap[DEQ_CAP_ZLT] || (mult != 2'h0);
   wire [10:0] mpl      = cap[DEQ_CAP_MPL_HI:DEQ_CAP_MPL_LO];
   wire [14:0] bytes    = tok[DEQ_TOK_BYT_HI:DEQ_TOK_BYT_LO];
   wire        active   = tok[DEQ_TOK_ACTIVE];
   wire [9:0]  nwords   = 10'(({1'b0, len_q} + 12'h003) >> 2);
   wire [14:0] rx_left  = bytes - {4'h0, len_q};
   wire        rx_short = len_q < mpl;
   wire        rx_ret   = rx_short || (rx_left == 15'h0 && zlt_dis);
   wire [10:0] plen     = (bytes > {4'h0, mpl}) ? mpl : bytes[10:0];
   wire [14:0] tx_left  = bytes - {4'h0, plen};
   wire        tx_ret   = (tx_left == 15'h0) && !((plen == mpl) && !zlt_dis);
   wire [1:0]  npkt     = (mult == 2'h0) ? 2'h1 : mult;
   wire        tx_last  = (tx_left == 15'h0) || (2'(pcnt + 2'h1) == npkt);
   wire        take_evt = i_evt_valid && o_ready;
   wire        take_pri = i_prime_valid && o_ready && !i_evt_valid;

   // Memory operation decode per state
   logic        op_mem;
   logic        op_we;
   logic        op_fifo;
   logic [31:0] op_addr;
   logic [31:0] op_wdata;
   always_comb begin
      op_mem   = 1'b1;
      op_we    = 1'b0;
      op_fifo  = 1'b0;
      op_addr  = qh;
      op_wdata = tok;
      unique case (state)
         S_NEXT_RD:  op_addr = qh + DEQ_QH_OVL;
         S_COPY_RD:  op_addr = nptr + {27'h0, k, 2'h0};
         S_COPY_WR: begin
            op_we    = 1'b1;
            op_addr  = qh + DEQ_QH_OVL + {27'h0, k, 2'h0};
            op_wdata = copy_q;
         end
         S_CUR_WR: begin
            op_we    = 1'b1;
            op_addr  = qh + DEQ_QH_CUR;
            op_wdata = nptr & DEQ_DTD_MASK;
         end
         S_CAP_RD:   op_addr = qh + DEQ_QH_CAP;
         S_TOK_RD:   op_addr = qh + DEQ_QH_TOK;
         S_BUF_RD:   op_addr = qh + DEQ_QH_BUF0;
         S_SETUP_WR: begin
            op_we    = 1'b1;
            op_fifo  = 1'b1;
            op_addr  = qh + DEQ_QH_SETUP0 + {20'h0, wcnt, 2'h0};
            op_wdata = f_data;
         end
         S_RX_WR: begin
            op_we    = 1'b1;
            op_fifo  = 1'b1;
            op_addr  = buf0 + {20'h0, wcnt, 2'h0};
            op_wdata = f_data;
         end
         S_TOK_WR: begin
            op_we    = 1'b1;
            op_addr  = qh + DEQ_QH_TOK;
         end
         S_BUF_WR: begin
            op_we    = 1'b1;
            op_addr  = qh + DEQ_QH_BUF0;
            op_wdata = buf0;
         end
         S_CUR_RD:   op_addr = qh + DEQ_QH_CUR;
         S_WB_WR: begin
            op_we    = 1'b1;
            op_addr  = (nptr & DEQ_DTD_MASK) + DEQ_DTD_TOK;
         end
         default:    op_mem = 1'b0;
      endcase
   end

   wire launch = op_mem && !mreq && (!op_fifo || f_valid);
   wire done   = mreq && mem.ack;
   assign f_pop = (launch && op_fifo) || (state == S_DRAIN && f_valid);
   assign mem.req   = mreq;
   assign mem.we    = mwe;
   assign mem.addr  = maddr;
   assign mem.wdata = mwdata;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mreq   <= 1'b0;
         mwe    <= 1'b0;
         maddr  <= 32'h0;
         mwdata <= 32'h0;
      end else if (launch) begin
         mreq   <= 1'b1;
         mwe    <= op_we;
         maddr  <= op_addr;
         mwdata <= op_wdata;
      end else if (done) begin
         mreq   <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= S_IDLE;
         {ep_q, dir_q, len_q, err_q, k, wcnt, pcnt, retire_q, advance_q} <= '0;
         kind_q <= DEQ_EVT_SETUP;
         {cap, tok, buf0, nptr, copy_q} <= '0;
         o_ready <= 1'b0;
         o_tx_valid <= 1'b0;
         o_tx_len <= 11'h0;
         o_transfer_interrupt_flag <= 1'b0;
      end else begin
         o_ready <= (state == S_IDLE) && !take_evt && !take_pri;
         o_tx_valid <= 1'b0;
         o_transfer_interrupt_flag <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (take_evt) begin
                  ep_q   <= i_evt_ep;
                  dir_q  <= (i_evt_kind == DEQ_EVT_IN);
                  kind_q <= i_evt_kind;
                  len_q  <= i_evt_len;
                  err_q  <= i_evt_err;
                  state  <= S_CAP_RD;
               end else if (take_pri) begin
                  ep_q  <= i_prime_ep;
                  dir_q <= i_prime_dir;
                  state <= S_NEXT_RD;
               end
            end
            S_NEXT_RD: if (done) begin
               nptr  <= mem.rdata;
               k     <= 3'h0;
               state <= mem.rdata[DEQ_NEXT_T] ? S_IDLE : S_COPY_RD;
            end
            S_COPY_RD: if (done) begin
               copy_q <= mem.rdata;
               state  <= S_COPY_WR;
            end
            S_COPY_WR: if (done) begin
               k     <= 3'(k + 3'h1);
               state <= (k == DEQ_OVL_LAST) ? S_CUR_WR : S_COPY_RD;
            end
            S_CUR_WR: if (done) state <= S_IDLE;
            S_CAP_RD: if (done) begin
               cap   <= mem.rdata;
               state <= S_TOK_RD;
            end
            S_TOK_RD: if (done) begin
               tok   <= mem.rdata;
               state <= S_BUF_RD;
            end
            S_BUF_RD: if (done) begin
               buf0  <= mem.rdata;
               wcnt  <= 10'h0;
               pcnt  <= 2'h0;
               state <= S_DISPATCH;
            end
            S_DISPATCH: begin
               advance_q <= 1'b1;
               if (kind_q == DEQ_EVT_SETUP) begin
                  state <= S_SETUP_WR;
               end else if (!active) begin
                  state <= (kind_q == DEQ_EVT_OUT && nwords != 10'h0) ? S_DRAIN : S_IDLE;
               end else if (err_q) begin
                  tok[DEQ_TOK_ACTIVE] <= 1'b0;
                  tok[DEQ_TOK_HALTED] <= 1'b1;
                  retire_q  <= 1'b1;
                  advance_q <= 1'b0;
                  state     <= S_TOK_WR;
               end else if (kind_q == DEQ_EVT_OUT) begin
                  tok[DEQ_TOK_BYT_HI:DEQ_TOK_BYT_LO] <= rx_left;
                  tok[DEQ_TOK_ACTIVE] <= !rx_ret;
                  retire_q <= rx_ret;
                  state    <= (nwords != 10'h0) ? S_RX_WR : S_TOK_WR;
               end else begin
                  state <= S_TX;
               end
            end
            S_SETUP_WR: if (done) begin
               wcnt <= 10'(wcnt + 10'h1);
               if (wcnt == 10'h1) begin
                  o_transfer_interrupt_flag <= cap[DEQ_CAP_IOS];
                  state <= S_IDLE;
               end
            end
            S_RX_WR: if (done) begin
               wcnt <= 10'(wcnt + 10'h1);
               if (10'(wcnt + 10'h1) == nwords) begin
                  buf0  <= buf0 + {21'h0, len_q};
                  state <= S_TOK_WR;
               end
            end
            S_DRAIN: if (f_valid) begin
               wcnt <= 10'(wcnt + 10'h1);
               if (10'(wcnt + 10'h1) == nwords) state <= S_IDLE;
            end
            S_TX: begin
               o_tx_valid <= 1'b1;
               o_tx_len   <= plen;
               tok[DEQ_TOK_BYT_HI:DEQ_TOK_BYT_LO] <= tx_left;
               buf0 <= buf0 + {21'h0, plen};
               pcnt <= 2'(pcnt + 2'h1);
               if (tx_last) begin
                  retire_q <= tx_ret;
                  tok[DEQ_TOK_ACTIVE] <= !tx_ret;
                  state <= S_TOK_WR;
               end
            end
            S_TOK_WR: if (done) state <= S_BUF_WR;
            S_BUF_WR: if (done) state <= retire_q ? S_CUR_RD : S_IDLE;
            S_CUR_RD: if (done) begin
               nptr  <= mem.rdata;
               state <= S_WB_WR;
            end
            S_WB_WR: if (done) begin
               o_transfer_interrupt_flag <= tok[DEQ_TOK_IOC];
               state <= advance_q ? S_NEXT_RD : S_IDLE;
            end
         endcase
      end
   end
endmodule

// *** deq_shared_memory.sv ***
// Shared memory end holding heads and descriptors for software
`timescale 1ns/1ns
module deq_shared_memory
   import deq_pkg::*;
#(
   parameter int MEM_WORDS = DEQ_MEM_WORDS
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Endpoint setup
   input  wire logic [31:0] i_endpoint_list_base,
   input  wire logic [31:0] i_ep_enabled,
   input  wire logic [31:0] i_ep_iso,
   // Software port
   input  wire logic        i_sw_valid,
   input  wire logic        i_sw_we,
   input  wire logic [31:0] i_sw_addr,
   input  wire logic [31:0] i_sw_wdata,
   output logic             o_sw_ack,
   output logic [31:0]      o_sw_rdata,
   output logic             o_sw_refused,
   // Engine port
   deq_mem_if.mem           mem
);
   localparam int AW = $clog2(MEM_WORDS);
   logic [31:0] store [MEM_WORDS];
   logic        ack_q;
   logic [31:0] rdata_q;

   function automatic logic [AW-1:0] widx(input logic [31:0] a);
      widx = a[AW+1:2];
   endfunction

   // Software write checks
   wire [31:0] off      = i_sw_addr - i_endpoint_list_base;
   wire        in_qh    = off < DEQ_QH_REGION;
   wire [4:0]  qh_idx   = off[10:6];
   wire [31:0] qh_in    = {26'h0, off[5:0]};
   wire [31:0] qh_tok   = store[widx(i_sw_addr - qh_in + DEQ_QH_TOK)];
   wire [31:0] dtd_base = i_sw_addr & DEQ_DTD_MASK;
   wire [31:0] dtd_tok  = store[widx(dtd_base + DEQ_DTD_TOK)];
   wire [1:0]  w_mult   = i_sw_wdata[DEQ_CAP_MULT_HI:DEQ_CAP_MULT_LO];
   wire [10:0] w_mpl    = i_sw_wdata[DEQ_CAP_MPL_HI:DEQ_CAP_MPL_LO];
   wire        cap_bad  = (qh_in == DEQ_QH_CAP) && (i_ep_enabled[qh_idx]
                          || ((w_mult == 2'h0) == i_ep_iso[qh_idx])
                          || (w_mpl > DEQ_MPL_MAX));
   wire        ovl_bad  = (qh_in >= DEQ_QH_OVL) && (qh_in <= DEQ_QH_OVL_END)
                          && qh_tok[DEQ_TOK_ACTIVE];
   wire        cur_bad  = (qh_in == DEQ_QH_CUR);
   wire        stp_bad  = (qh_in >= DEQ_QH_SETUP0) && (qh_in < DEQ_QH_BYTES);
   wire        dtd_bad  = !in_qh && dtd_tok[DEQ_TOK_ACTIVE] && (i_sw_addr != dtd_base);
   wire        sw_bad   = in_qh ? (cap_bad || ovl_bad || cur_bad || stp_bad) : dtd_bad;
   wire        take_dma = mem.req && !ack_q;
   wire        take_sw  = i_sw_valid && !o_sw_ack && !take_dma;
   wire        sw_write = take_sw && i_sw_we && !sw_bad;

   assign mem.ack   = ack_q;
   assign mem.rdata = rdata_q;

   // Cleared so refusal checks never read an unknown token
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            store[i] <= 32'h0;
         end
      end else if (take_dma && mem.we) begin
         store[widx(mem.addr)] <= mem.wdata;
      end else if (sw_write) begin
         store[widx(i_sw_addr)] <= i_sw_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_q        <= 1'b0;
         rdata_q      <= 32'h0;
         o_sw_ack     <= 1'b0;
         o_sw_rdata   <= 32'h0;
         o_sw_refused <= 1'b0;
      end else begin
         ack_q        <= take_dma;
         rdata_q      <= take_dma ? store[widx(mem.addr)] : rdata_q;
         o_sw_ack     <= take_sw;
         o_sw_rdata   <= take_sw ? store[widx(i_sw_addr)] : o_sw_rdata;
         o_sw_refused <= take_sw && i_sw_we && sw_bad;
      end
   end
endmodule

// *** deq_mem_checker.sv ***
// Assertions on the shared memory link between the engine and the memory end
`timescale 1ns/1ns
module deq_mem_checker
   import deq_pkg::*;
#(
   parameter logic [31:0] BASE = 32'h0000_0000
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Link signals
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [31:0] rdata,
   input  wire logic        ack
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Address relative to the head array, head or descriptor token writes
   wire logic [31:0] rel    = addr - BASE;
   wire logic        in_hd  = rel < DEQ_QH_REGION;
   wire logic        tok_wr = req && we && (in_hd ? rel[5:0] == 6'h0c : rel[4:0] == 5'h04);

   sequence s_take;
      req && !ack;
   endsequence
   sequence s_done;
      ##1 ack ##1 !req;
   endsequence

   link_handshake_a: assert property (s_take |-> s_done)
      else $error("memory request not answered in one cycle");
   req_stable_a: assert property (s_take |=> $stable(addr) && $stable(we) && $stable(wdata))
      else $error("request changed before answer");
   ack_pulse_a: assert property (ack |-> req ##1 !ack)
      else $error("answer without request or longer than one cycle");
   word_align_a: assert property (req |-> addr[1:0] == 2'h0)
      else $error("unaligned memory access");
   head_span_a: assert property (req && in_hd |-> rel[5:0] < 6'h30)
      else $error("head access beyond 48 bytes");
   cur_low_a: assert property (req && we && in_hd && rel[5:0] == 6'h04 |-> wdata[4:0] == 5'h00)
      else $error("current pointer written with low bits set");
   setup_rx_a: assert property (req && we && in_hd && rel[5:0] >= 6'h28 |-> !rel[6])
      else $error("setup data written to transmit head");
   halt_clear_a: assert property (tok_wr && wdata[DEQ_TOK_HALTED] |-> !wdata[DEQ_TOK_ACTIVE])
      else $error("halted token left active");
endmodule

// *** device_endpoint_queue_head_test.sv ***
// Self-checking bench for the queue head engine and its shared memory
`timescale 1ns/1ns
module device_endpoint_queue_head_test
   import deq_pkg::*;
;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [31:0] ep_en = 32'h0;
   logic        prime_valid = 1'b0;
   logic [3:0]  prime_ep = 4'h0;
   logic        prime_dir = 1'b0;
   logic        evt_valid = 1'b0;
   deq_evt_t    evt_kind = DEQ_EVT_OUT;
   logic [3:0]  evt_ep = 4'h0;
   logic [10:0] evt_len = 11'h0;
   logic        evt_err = 1'b0;
   logic        rx_valid = 1'b0;
   logic [31:0] rx_data = 32'h0;
   logic        sw_valid = 1'b0;
   logic        sw_we = 1'b0;
   logic [31:0] sw_addr = 32'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic        ready, rx_ready, tx_valid, irq, sw_ack, sw_ref;
   logic [10:0] tx_len;
   logic [10:0] tx_len_seen = 11'h0;
   logic [31:0] sw_rdata;
   int          fail_count = 0;
   int          n_checks = 0;
   int          irq_n = 0;
   int          tx_n = 0;
   // Address and data pairs written by software before the run
   localparam logic [63:0] INIT [0:16] = '{
      64'h0000_0000_0008_8000, 64'h0000_0080_2008_0000, 64'h0000_008c_0000_0000, 64'h0000_0088_0000_0800,
      64'h0000_00c0_0008_0000, 64'h0000_00cc_0000_0000, 64'h0000_00c8_0000_0840, 64'h0000_0908_0000_0000,
      64'h0000_0800_0000_0001, 64'h0000_0808_0000_0900, 64'h0000_0804_0008_8080, 64'h0000_0840_0000_0001,
      64'h0000_0848_0000_0980, 64'h0000_0844_0008_0080, 64'h0000_0820_0000_0001, 64'h0000_0828_0000_0a00,
      64'h0000_0824_0008_0080};

   always #2 i_clk = ~i_clk;

   deq_mem_if u_deq_mem_if ();

   deq_controller u_deq_controller (
      .i_clk(i_clk), .i_rst(i_rst), .i_endpoint_list_base(32'h0),
      .i_prime_valid(prime_valid), .i_prime_ep(prime_ep), .i_prime_dir(prime_dir),
      .i_evt_valid(evt_valid), .i_evt_kind(evt_kind), .i_evt_ep(evt_ep), .i_evt_len(evt_len),
      .i_evt_err(evt_err), .o_ready(ready), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_len(tx_len),
      .o_transfer_interrupt_flag(irq), .mem(u_deq_mem_if.ctrl));

   deq_shared_memory #(.MEM_WORDS(1024)) u_deq_shared_memory (
      .i_clk(i_clk), .i_rst(i_rst), .i_endpoint_list_base(32'h0), .i_ep_enabled(ep_en),
      .i_ep_iso(32'h0), .i_sw_valid(sw_valid), .i_sw_we(sw_we), .i_sw_addr(sw_addr),
      .i_sw_wdata(sw_wdata), .o_sw_ack(sw_ack), .o_sw_rdata(sw_rdata), .o_sw_refused(sw_ref),
      .mem(u_deq_mem_if.mem));

   deq_mem_checker #(.BASE(32'h0)) u_deq_mem_checker (
      .i_clk(i_clk), .i_rst(i_rst), .req(u_deq_mem_if.req), .we(u_deq_mem_if.we),
      .addr(u_deq_mem_if.addr), .wdata(u_deq_mem_if.wdata), .rdata(u_deq_mem_if.rdata),
      .ack(u_deq_mem_if.ack));

   // Pulse counters
   always @(posedge i_clk) begin
      if (irq === 1'b1) irq_n <= irq_n + 1;
      if (tx_valid === 1'b1) begin
         tx_n <= tx_n + 1;
         tx_len_seen <= tx_len;
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic sw_op(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic r);
      int n = 0;
      @(posedge i_clk);
      #1;
      sw_valid = 1'b1;
      sw_we = w;
      sw_addr = a;
      sw_wdata = d;
      do @(posedge i_clk); while (sw_ack !== 1'b1 && ++n < 50);
      if (n >= 50) fail_count++;
      q = sw_rdata;
      r = sw_ref;
      #1 sw_valid = 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      logic        r;
      sw_op(1'b0, a, 32'h0, q, r);
      check(nm, q, e);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic e);
      logic [31:0] q;
      logic        r;
      sw_op(1'b1, a, d, q, r);
      check("write refused", {31'h0, r}, {31'h0, e});
   endtask

   task automatic push(input logic [31:0] w);
      int n = 0;
      @(posedge i_clk);
      #1;
      rx_valid = 1'b1;
      rx_data = w;
      do @(posedge i_clk); while (rx_ready !== 1'b1 && ++n < 50);
      if (n >= 50) fail_count++;
      #1 rx_valid = 1'b0;
   endtask

   // Prime or bus event, then wait until the engine is idle again
   task automatic go(input logic pr, input deq_evt_t k, input logic [3:0] ep, input logic dir,
                     input logic [10:0] len, input logic err);
      int n = 0;
      @(posedge i_clk);
      #1;
      prime_valid = pr;
      evt_valid = !pr;
      prime_ep = ep;
      prime_dir = dir;
      evt_kind = k;
      evt_ep = ep;
      evt_len = len;
      evt_err = err;
      do @(posedge i_clk); while (ready !== 1'b1 && ++n < 50);
      #1;
      prime_valid = 1'b0;
      evt_valid = 1'b0;
      repeat (2) @(posedge i_clk);
      do @(posedge i_clk); while (ready !== 1'b1 && ++n < 500);
      if (n >= 500) fail_count++;
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (3) @(posedge i_clk);
      foreach (INIT[i]) wr(INIT[i][63:32], INIT[i][31:0], 1'b0);
      wr(32'h100, 32'h0401_0000, 1'b1);
      wr(32'h140, 32'h4008_0000, 1'b1);
      ep_en = 32'h0000_000d;
      wr(32'h04, 32'h0000_0800, 1'b1);
      wr(32'h2c, 32'h0, 1'b1);
      wr(32'h00, 32'h0008_0000, 1'b1);
      // Setup capture into the receive head of endpoint 0
      push(32'h1234_5678);
      push(32'h9abc_def0);
      go(1'b0, DEQ_EVT_SETUP, 4'h0, 1'b0, 11'h0, 1'b0);
      rd(32'h28, 32'h1234_5678, "setup low");
      rd(32'h2c, 32'h9abc_def0, "setup high");
      check("setup flag", 32'(irq_n), 32'h1);
      // Prime endpoint 1 receive head
      go(1'b1, DEQ_EVT_OUT, 4'h1, 1'b0, 11'h0, 1'b0);
      rd(32'h84, 32'h0000_0800, "current ptr");
      rd(32'h8c, 32'h0008_8080, "overlay token");
      rd(32'h90, 32'h0000_0900, "overlay buf0");
      wr(32'h90, 32'h0, 1'b1);
      wr(32'h808, 32'h0, 1'b1);
      wr(32'h800, 32'h1, 1'b0);
      // Full receive with termination disabled retires at zero bytes
      push(32'h0403_0201);
      push(32'h0807_0605);
      go(1'b0, DEQ_EVT_OUT, 4'h1, 1'b0, 11'h8, 1'b0);
      rd(32'h900, 32'h0403_0201, "data word 0");
      rd(32'h904, 32'h0807_0605, "data word 1");
      rd(32'h804, 32'h0000_8000, "status back");
      check("complete flag", 32'(irq_n), 32'h2);
      // Inactive overlay is not serviced
      push(32'h1111_2222);
      go(1'b0, DEQ_EVT_OUT, 4'h1, 1'b0, 11'h4, 1'b0);
      rd(32'h908, 32'h0, "idle buffer");
      check("idle flag", 32'(irq_n), 32'h2);
      // Transmit of a full last packet appends a zero-length packet
      go(1'b1, DEQ_EVT_IN, 4'h1, 1'b1, 11'h0, 1'b0);
      go(1'b0, DEQ_EVT_IN, 4'h1, 1'b1, 11'h0, 1'b0);
      check("tx count", 32'(tx_n), 32'h1);
      check("tx length", {21'h0, tx_len_seen}, 32'h8);
      rd(32'h844, 32'h0008_0080, "not retired");
      go(1'b0, DEQ_EVT_IN, 4'h1, 1'b1, 11'h0, 1'b0);
      check("zlp count", 32'(tx_n), 32'h2);
      check("zlp length", {21'h0, tx_len_seen}, 32'h0);
      rd(32'h844, 32'h0, "tx retired");
      // Failed transaction halts and clears active
      wr(32'h88, 32'h0000_0820, 1'b0);
      go(1'b1, DEQ_EVT_OUT, 4'h1, 1'b0, 11'h0, 1'b0);
      go(1'b0, DEQ_EVT_OUT, 4'h1, 1'b0, 11'h0, 1'b1);
      rd(32'h824, 32'h0008_0040, "halted dtd");
      rd(32'h8c, 32'h0008_0040, "halted overlay");
      finish_test();
   end
endmodule
